//--- rtl/ppfio_pkg.sv
// Shared constants for the port 1 / port 2 pin function logic
package ppfio_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int P1_W = 8;
  localparam int P2_W = 3;
  localparam int P5_W = 2;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_P1_MODE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_P1_DIR = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_P1_DATA = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_P2_DIR = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_P2_DATA = 4'h4;

  // Mode register field positions
  localparam int MODE_EXT_INTERRUPT1_BIT = 5;
  localparam int MODE_EXT_INTERRUPT0_BIT = 4;
  localparam int MODE_TXD_BIT = 1;
  localparam int MODE_WATCH_TIMER_OUT_BIT = 0;

  // Port 1 pins that exist in this block
  localparam logic [P1_W-1:0] P1_IMPL_MASK = 8'h37;
  localparam int P1_BIT5 = 5;
  localparam int P1_BIT4 = 4;
  localparam int P1_BIT0 = 0;

  // Port 2 pin positions
  localparam int P2_BIT2 = 2;
  localparam int P2_BIT1 = 1;
  localparam int P2_BIT0 = 0;

  // Reset values
  localparam logic [DATA_W-1:0] MODE_RESET = 8'h00;
  localparam logic [P1_W-1:0] P1_DIR_RESET = 8'h00;
  localparam logic [P1_W-1:0] P1_DATA_RESET = 8'h00;
  localparam logic [P2_W-1:0] P2_DIR_RESET = 3'h0;
  localparam logic [P2_W-1:0] P2_DATA_RESET = 3'h0;

  // Bits that read as one whatever is stored
  localparam logic [DATA_W-1:0] MODE_RSVD_ONES = 8'h0c;
  localparam logic [DATA_W-1:0] P1_DATA_RSVD_ONES = 8'h08;
  localparam logic [DATA_W-1:0] P2_DATA_RSVD_ONES = 8'hf8;

  // Answer for write-only and unmapped reads
  localparam logic [DATA_W-1:0] READ_NONE = 8'h00;

  // Idle level handed to the receiver when its pin is not selected
  localparam logic RX_IDLE = 1'h1;

endpackage

//--- rtl/ppfio_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ppfio_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous pins in, filtered levels out
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only once two later stages agree
  for (genvar i = 0; i < W; i++)
  begin : g_filt
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        level_q[i] <= 1'b0;
      else if (s2_q[i] == s3_q[i])
        level_q[i] <= s3_q[i];
    end
  end

  assign level_o = level_q;

endmodule // ppfio_sync

//--- rtl/ppfio_top.sv
// Port 1 and port 2 pin function selection, direction and data
//
// How it works
// R1: Mode bit one makes bit5 interrupt-1 input
// R2: Mode bit one makes bit4 interrupt-0 input
// R3: Port1 bits 2,1 plain direction-controlled I/O
// R4: Mode bit one drives watch timer on bit0
// R5: Mode and serial settings override port2 I/O
// R6: Port2 direction bits write-only, reset zero
// R7: Port2 data bits 7..3 read one
// R8: Port2 latches reset zero, drive general outputs
// R9: Output-direction read returns latched value
// R10: Input-direction read returns pin level
// R11: Transmit select puts serial data on bit2
// R12: Receive enable makes bit1 serial input
// R13: Clock select one makes bit0 clock input
// R14: Clock output on select0 or comm mode
// R15: All serial bits zero: plain I/O
// R16: I2C settings override port5 bits 7,6
// R17: Port1 direction bits write-only, reset zero
// R18: Input pins leave output buffer off
`timescale 1ns/1ps
module ppfio_top
  import ppfio_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [ppfio_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ppfio_pkg::DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [ppfio_pkg::DATA_W-1:0] rdata_o,
  // Port 1 pins
  input wire logic [ppfio_pkg::P1_W-1:0] port1_pin_i,
  output logic [ppfio_pkg::P1_W-1:0] port1_pin_o,
  output logic [ppfio_pkg::P1_W-1:0] port1_pin_oe_o,
  // Port 2 pins
  input wire logic [ppfio_pkg::P2_W-1:0] port2_pin_i,
  output logic [ppfio_pkg::P2_W-1:0] port2_pin_o,
  output logic [ppfio_pkg::P2_W-1:0] port2_pin_oe_o,
  // Port 5 pins 7 and 6, outputs only
  output logic [ppfio_pkg::P5_W-1:0] port5_pin_o,
  output logic [ppfio_pkg::P5_W-1:0] port5_pin_oe_o,
  // Port 5 general I/O request from its own port logic
  input wire logic [ppfio_pkg::P5_W-1:0] port5_gpio_out_i,
  input wire logic [ppfio_pkg::P5_W-1:0] port5_gpio_oe_i,
  // I2C interface request for the same pins
  input wire logic i2c_enable_i,
  input wire logic [ppfio_pkg::P5_W-1:0] i2c_out_i,
  input wire logic [ppfio_pkg::P5_W-1:0] i2c_oe_i,
  // Serial unit settings
  input wire logic receive_enable_bit_i,
  input wire logic clock_select_bit1_i,
  input wire logic clock_select_bit0_i,
  input wire logic comm_mode_bit_i,
  // Serial unit data and clock
  input wire logic serial_tx_data_i,
  input wire logic serial_clock_out_i,
  output logic serial_rx_data_o,
  output logic serial_clock_in_o,
  // Timer and interrupt connections
  input wire logic watch_timer_out_i,
  output logic ext_interrupt0_o,
  output logic ext_interrupt1_o
);

  // Register state
  logic [DATA_W-1:0] port1_mode_select_reg_q;
  logic [P1_W-1:0] port1_direction_reg_q;
  logic [P1_W-1:0] port1_data_reg_q;
  logic [P2_W-1:0] port2_direction_reg_q;
  logic [P2_W-1:0] port2_data_reg_q;

  // Filtered pin levels
  logic [P1_W-1:0] p1_level;
  logic [P2_W-1:0] p2_level;

  // Pad drive, next values
  logic [P1_W-1:0] p1_out_d;
  logic [P1_W-1:0] p1_oe_d;
  logic [P2_W-1:0] p2_out_d;
  logic [P2_W-1:0] p2_oe_d;

  // Registered outputs
  logic [DATA_W-1:0] rdata_q;
  logic [P1_W-1:0] p1_out_q;
  logic [P1_W-1:0] p1_oe_q;
  logic [P2_W-1:0] p2_out_q;
  logic [P2_W-1:0] p2_oe_q;
  logic [P5_W-1:0] p5_out_q;
  logic [P5_W-1:0] p5_oe_q;
  logic rx_q;
  logic sclk_in_q;
  logic ext_interrupt0_q;
  logic ext_interrupt1_q;

  // Decoded selects
  logic sel_ext_interrupt1;
  logic sel_ext_interrupt0;
  logic sel_txd;
  logic sel_watch_timer_out;
  logic sck_in_sel;
  logic sck_out_sel;

  // Read path helpers
  logic [P1_W-1:0] p1_read;
  logic [P2_W-1:0] p2_read;
  logic [DATA_W-1:0] rdata_d;

  logic wr_mode;
  logic wr_p1_dir;
  logic wr_p1_data;
  logic wr_p2_dir;
  logic wr_p2_data;

  // Pins arrive from outside the clock domain
  ppfio_sync #(
    .W(P1_W)
  ) u_sync_p1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(port1_pin_i),
    .level_o(p1_level)
  );

  ppfio_sync #(
    .W(P2_W)
  ) u_sync_p2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(port2_pin_i),
    .level_o(p2_level)
  );

  // Write decode
  assign wr_mode = we_i && (addr_i == OFS_P1_MODE);
  assign wr_p1_dir = we_i && (addr_i == OFS_P1_DIR);
  assign wr_p1_data = we_i && (addr_i == OFS_P1_DATA);
  assign wr_p2_dir = we_i && (addr_i == OFS_P2_DIR);
  assign wr_p2_data = we_i && (addr_i == OFS_P2_DATA);

  // Only the four switch bits are stored
  localparam logic [DATA_W-1:0] MODE_WMASK =
    DATA_W'((1 << MODE_EXT_INTERRUPT1_BIT) | (1 << MODE_EXT_INTERRUPT0_BIT) |
            (1 << MODE_TXD_BIT) | (1 << MODE_WATCH_TIMER_OUT_BIT));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port1_mode_select_reg_q <= MODE_RESET;
    else if (wr_mode)
      port1_mode_select_reg_q <= wdata_i & MODE_WMASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port1_direction_reg_q <= P1_DIR_RESET; // [R17]
    else if (wr_p1_dir)
      port1_direction_reg_q <= wdata_i & P1_IMPL_MASK; // [R17]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port1_data_reg_q <= P1_DATA_RESET;
    else if (wr_p1_data)
      port1_data_reg_q <= wdata_i & P1_IMPL_MASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port2_direction_reg_q <= P2_DIR_RESET; // [R6]
    else if (wr_p2_dir)
      port2_direction_reg_q <= wdata_i[P2_W-1:0]; // [R6]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port2_data_reg_q <= P2_DATA_RESET; // [R8]
    else if (wr_p2_data)
      port2_data_reg_q <= wdata_i[P2_W-1:0]; // [R8]
  end

  // Function selects
  assign sel_ext_interrupt1 = port1_mode_select_reg_q[MODE_EXT_INTERRUPT1_BIT];
  assign sel_ext_interrupt0 = port1_mode_select_reg_q[MODE_EXT_INTERRUPT0_BIT];
  assign sel_txd = port1_mode_select_reg_q[MODE_TXD_BIT];
  assign sel_watch_timer_out = port1_mode_select_reg_q[MODE_WATCH_TIMER_OUT_BIT];
  assign sck_in_sel = clock_select_bit1_i; // [R13]
  assign sck_out_sel = !clock_select_bit1_i &&
    (clock_select_bit0_i || comm_mode_bit_i); // [R14]

  // Port 1 pad drive
  always_comb
  begin
    p1_out_d = port1_data_reg_q & P1_IMPL_MASK;
    p1_oe_d = port1_direction_reg_q & P1_IMPL_MASK; // [R3] [R17]
    if (sel_ext_interrupt1)
      p1_oe_d[P1_BIT5] = 1'b0; // [R1] [R18]
    if (sel_ext_interrupt0)
      p1_oe_d[P1_BIT4] = 1'b0; // [R2] [R18]
    if (sel_watch_timer_out)
    begin
      p1_oe_d[P1_BIT0] = 1'b1; // [R4]
      p1_out_d[P1_BIT0] = watch_timer_out_i; // [R4]
    end
  end

  // Port 2 pad drive; alternate functions win over direction
  always_comb
  begin
    p2_out_d = port2_data_reg_q; // [R8]
    p2_oe_d = port2_direction_reg_q; // [R6] [R15]
    if (sel_txd)
    begin
      p2_oe_d[P2_BIT2] = 1'b1; // [R5] [R11]
      p2_out_d[P2_BIT2] = serial_tx_data_i; // [R11]
    end
    if (receive_enable_bit_i)
      p2_oe_d[P2_BIT1] = 1'b0; // [R5] [R12] [R18]
    if (sck_in_sel)
      p2_oe_d[P2_BIT0] = 1'b0; // [R13] [R18]
    else if (sck_out_sel)
    begin
      p2_oe_d[P2_BIT0] = 1'b1; // [R5] [R14]
      p2_out_d[P2_BIT0] = serial_clock_out_i; // [R14]
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      p1_out_q <= '0;
      p1_oe_q <= '0;
    end
    else
    begin
      p1_out_q <= p1_out_d;
      p1_oe_q <= p1_oe_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      p2_out_q <= '0;
      p2_oe_q <= '0;
    end
    else
    begin
      p2_out_q <= p2_out_d;
      p2_oe_q <= p2_oe_d;
    end
  end

  // Port 5 bits 7 and 6: I2C owns the pins when enabled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      p5_out_q <= '0;
      p5_oe_q <= '0;
    end
    else if (i2c_enable_i)
    begin
      p5_out_q <= i2c_out_i; // [R16]
      p5_oe_q <= i2c_oe_i; // [R16]
    end
    else
    begin
      p5_out_q <= port5_gpio_out_i;
      p5_oe_q <= port5_gpio_oe_i;
    end
  end

  // Alternate inputs to peripherals; unselected ones sit at rest
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_interrupt0_q <= 1'b0;
      ext_interrupt1_q <= 1'b0;
    end
    else
    begin
      ext_interrupt1_q <= sel_ext_interrupt1 && p1_level[P1_BIT5]; // [R1]
      ext_interrupt0_q <= sel_ext_interrupt0 && p1_level[P1_BIT4]; // [R2]
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_q <= RX_IDLE;
      sclk_in_q <= 1'b0;
    end
    else
    begin
      rx_q <= receive_enable_bit_i ? p2_level[P2_BIT1] : RX_IDLE; // [R12]
      sclk_in_q <= sck_in_sel && p2_level[P2_BIT0]; // [R13]
    end
  end

  // Per-bit read-back: latch when output, pin when input
  for (genvar i = 0; i < P2_W; i++)
  begin : g_p2_read
    assign p2_read[i] = port2_direction_reg_q[i] ?
      port2_data_reg_q[i] : // [R9]
      p2_level[i]; // [R10]
  end

  for (genvar i = 0; i < P1_W; i++)
  begin : g_p1_read
    assign p1_read[i] = P1_IMPL_MASK[i] &&
      (port1_direction_reg_q[i] ? port1_data_reg_q[i] : p1_level[i]);
  end

  // Direction registers are write-only and read as zero
  always_comb
  begin
    rdata_d = READ_NONE;
    unique case (addr_i)
      OFS_P1_MODE: rdata_d = port1_mode_select_reg_q | MODE_RSVD_ONES;
      OFS_P1_DATA: rdata_d = p1_read | P1_DATA_RSVD_ONES;
      OFS_P2_DATA: rdata_d = DATA_W'(p2_read) | P2_DATA_RSVD_ONES; // [R7]
      default: rdata_d = READ_NONE;
    endcase
  end

  // Data valid only the cycle after the read strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_q <= READ_NONE;
    else if (re_i)
      rdata_q <= rdata_d;
    else
      rdata_q <= READ_NONE;
  end

  assign rdata_o = rdata_q;
  assign port1_pin_o = p1_out_q;
  assign port1_pin_oe_o = p1_oe_q;
  assign port2_pin_o = p2_out_q;
  assign port2_pin_oe_o = p2_oe_q;
  assign port5_pin_o = p5_out_q;
  assign port5_pin_oe_o = p5_oe_q;
  assign serial_rx_data_o = rx_q;
  assign serial_clock_in_o = sclk_in_q;
  assign ext_interrupt0_o = ext_interrupt0_q;
  assign ext_interrupt1_o = ext_interrupt1_q;

endmodule // ppfio_top

//--- verif/ppfio_top_monitor.sv
// Port-level assertions for the pin function block
`timescale 1ns/1ps
module ppfio_top_monitor
  import ppfio_pkg::*;
(
  // Clock, reset and register port
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [7:0] rdata_o,
  // Pads and peripheral levels
  input wire logic [7:0] port1_pin_o,
  input wire logic [7:0] port1_pin_oe_o,
  input wire logic [2:0] port2_pin_o,
  input wire logic [2:0] port2_pin_oe_o,
  input wire logic receive_enable_bit_i,
  input wire logic clock_select_bit1_i,
  input wire logic clock_select_bit0_i,
  input wire logic comm_mode_bit_i,
  input wire logic serial_tx_data_i,
  input wire logic serial_clock_out_i,
  input wire logic watch_timer_out_i
);
  logic rst_d;
  logic [7:0] mode_q;
  logic [7:0] p1dir_q;
  logic [2:0] p2dir_q;
  logic [2:0] p2dat_q;

  // Shadow registers, so pad checks need no view inside
  always_ff @(posedge clk_i)
  begin
    rst_d <= rst_i;
    if (rst_i)
    begin
      mode_q <= 8'h00;
      p1dir_q <= 8'h00;
      p2dir_q <= 3'h0;
      p2dat_q <= 3'h0;
    end
    else if (we_i)
    begin
      case (addr_i)
        OFS_P1_MODE: mode_q <= wdata_i;
        OFS_P1_DIR: p1dir_q <= wdata_i;
        OFS_P2_DIR: p2dir_q <= wdata_i[2:0];
        OFS_P2_DATA: p2dat_q <= wdata_i[2:0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  // First edge after release still shows reset-time inputs
  default disable iff (rst_i || rst_d);

  sequence p2_read_s;
    re_i && addr_i == OFS_P2_DATA;
  endsequence

  p2_rsvd_a: assert property (p2_read_s |=> rdata_o[7:3] == 5'h1f)
    else $error("reserved bits not one");
  p2_latch_a: assert property (p2_read_s |=>
    ((rdata_o[2:0] ^ $past(p2dat_q)) & $past(p2dir_q)) == 3'h0)
    else $error("latch read wrong");
  rx_input_a: assert property (receive_enable_bit_i |=>
    !port2_pin_oe_o[1]) else $error("rx pad driven");
  clk_input_a: assert property (clock_select_bit1_i |=>
    !port2_pin_oe_o[0]) else $error("clock in pad driven");
  clk_output_a: assert property (!clock_select_bit1_i &&
    (clock_select_bit0_i || comm_mode_bit_i) |=> port2_pin_oe_o[0] &&
    port2_pin_o[0] == $past(serial_clock_out_i))
    else $error("clock out wrong");
  clk_plain_a: assert property (!clock_select_bit1_i &&
    !clock_select_bit0_i && !comm_mode_bit_i |=>
    port2_pin_oe_o[0] == $past(p2dir_q[0])) else $error("bit0 dir");
  tx_output_a: assert property (mode_q[MODE_TXD_BIT] |=>
    port2_pin_oe_o[2] && port2_pin_o[2] == $past(serial_tx_data_i))
    else $error("tx pad wrong");
  timer_out_a: assert property (mode_q[MODE_WATCH_TIMER_OUT_BIT] |=>
    port1_pin_oe_o[0] && port1_pin_o[0] == $past(watch_timer_out_i))
    else $error("timer pad wrong");
  ext_interrupt1_input_a: assert property (mode_q[MODE_EXT_INTERRUPT1_BIT] |=>
    !port1_pin_oe_o[5]) else $error("ext_interrupt1 pad driven");
  ext_interrupt0_input_a: assert property (mode_q[MODE_EXT_INTERRUPT0_BIT] |=>
    !port1_pin_oe_o[4]) else $error("ext_interrupt0 pad driven");
  p1_plain_a: assert property (##1
    port1_pin_oe_o[2:1] == $past(p1dir_q[2:1])) else $error("p1 dir");
endmodule // ppfio_top_monitor

//--- verif/ppfio_pin_model.sv
// Outside world of the pads: the block wins where it drives
`timescale 1ns/1ps
module ppfio_pin_model (
  // Block side
  input wire logic [7:0] p1_out_i,
  input wire logic [7:0] p1_oe_i,
  input wire logic [2:0] p2_out_i,
  input wire logic [2:0] p2_oe_i,
  // Outside levels and resolved pads
  input wire logic [7:0] p1_ext_i,
  input wire logic [2:0] p2_ext_i,
  output logic [7:0] p1_pad_o,
  output logic [2:0] p2_pad_o
);
  assign p1_pad_o = (p1_out_i & p1_oe_i) | (p1_ext_i & ~p1_oe_i);
  assign p2_pad_o = (p2_out_i & p2_oe_i) | (p2_ext_i & ~p2_oe_i);
endmodule // ppfio_pin_model

//--- verif/tb_ppfio_top.sv
// Self-checking bench for the pin function block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_ppfio_top;
  import ppfio_pkg::*;
  logic clk_i = 0, rst_i = 1, we_i = 0, re_i = 0;
  logic [3:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rv, p1_ext = 0, p1_pad, port1_pin_o, port1_pin_oe_o;
  logic [2:0] p2_ext = 3'h5, p2_pad, port2_pin_o, port2_pin_oe_o;
  logic [1:0] g_out = 0, g_oe = 0, i_out = 0, i_oe = 0, p5_o, p5_oe;
  logic i2c_en = 0, rxe = 0, ck1 = 0, ck0 = 0, com = 0, txd = 0, cko = 0;
  logic wto = 0, rxd, cki, ext_interrupt0, ext_interrupt1;
  logic [7:0] rdv;
  int errors = 0, comparisons = 0;

  always #12.5 clk_i = ~clk_i;

  ppfio_pin_model ppfio_pin_model_inst (.p1_out_i(port1_pin_o),
    .p1_oe_i(port1_pin_oe_o), .p2_out_i(port2_pin_o),
    .p2_oe_i(port2_pin_oe_o), .p1_ext_i(p1_ext), .p2_ext_i(p2_ext),
    .p1_pad_o(p1_pad), .p2_pad_o(p2_pad));
  ppfio_top ppfio_top_inst (.clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i,
    .rdata_o(rv), .port1_pin_i(p1_pad), .port1_pin_o, .port1_pin_oe_o,
    .port2_pin_i(p2_pad), .port2_pin_o, .port2_pin_oe_o, .port5_pin_o(p5_o),
    .port5_pin_oe_o(p5_oe), .port5_gpio_out_i(g_out), .port5_gpio_oe_i(g_oe),
    .i2c_enable_i(i2c_en), .i2c_out_i(i_out), .i2c_oe_i(i_oe),
    .receive_enable_bit_i(rxe), .clock_select_bit1_i(ck1),
    .clock_select_bit0_i(ck0), .comm_mode_bit_i(com), .serial_tx_data_i(txd),
    .serial_clock_out_i(cko), .serial_rx_data_o(rxd),
    .serial_clock_in_o(cki), .watch_timer_out_i(wto),
    .ext_interrupt0_o(ext_interrupt0), .ext_interrupt1_o(ext_interrupt1));

  task automatic pause(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    pause(1);
    we_i <= 1'b0;
    pause(1);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr_i <= a;
    re_i <= 1'b1;
    pause(1);
    re_i <= 1'b0;
    @(negedge clk_i);
    d = rv;
    pause(1);
  endtask
  task automatic end_of_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    pause(3);
    rst_i <= 1'b0;
    pause(6);
    `CHK({port2_pin_oe_o, port2_pin_o}, 6'h00)
    `CHK(port1_pin_oe_o, 8'h00)
    `CHK({rxd, cki, ext_interrupt1, ext_interrupt0}, 4'b1000)
    wr(OFS_P2_DATA, 8'h03);
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_P2_DIR, 8'(i));
      pause(6);
      `CHK(port2_pin_oe_o, 3'(i))
      `CHK(port2_pin_o & 3'(i), 3'(3 & i))
      rd(OFS_P2_DATA, rdv);
      `CHK(rdv, 8'hf8 | 8'(3 & i) | 8'(5 & ~i & 7))
    end
    txd <= 1'b1;
    rxe <= 1'b1;
    wr(OFS_P1_MODE, 8'h02);
    pause(6);
    `CHK({port2_pin_oe_o[2:1], port2_pin_o[2]}, 3'b101)
    `CHK(rxd, 1'b0)
    for (int j = 0; j < 8; j++)
    begin
      {ck1, ck0, com} <= 3'(j);
      // Clock-in level needs six edges from the select change
      pause(7);
      `CHK(port2_pin_oe_o[0], j < 4)
      if (j < 4)
        `CHK(port2_pin_o[0], j == 0)
      `CHK(cki, j >= 4)
    end
    p1_ext <= 8'h30;
    wto <= 1'b1;
    wr(OFS_P1_DIR, 8'h37);
    wr(OFS_P1_MODE, 8'h31);
    pause(6);
    `CHK({port1_pin_oe_o, port1_pin_o[0]}, 9'h00f)
    `CHK({ext_interrupt1, ext_interrupt0}, 2'b11)
    wr(OFS_P1_MODE, 8'h00);
    pause(6);
    `CHK({port1_pin_oe_o, port1_pin_o[0]}, 9'h06e)
    `CHK({ext_interrupt1, ext_interrupt0}, 2'b00)
    g_out <= 2'b01;
    g_oe <= 2'b11;
    i_out <= 2'b10;
    i_oe <= 2'b01;
    pause(3);
    `CHK({p5_o, p5_oe}, 4'b0111)
    i2c_en <= 1'b1;
    pause(3);
    `CHK({p5_o, p5_oe}, 4'b1001)
    rd(4'hf, rdv);
    `CHK(rdv, 8'h00)
    end_of_test();
  end

  initial
  begin
    pause(5000);
    errors++;
    end_of_test();
  end
endmodule // tb_ppfio_top

bind ppfio_top ppfio_top_monitor ppfio_top_monitor_inst (.clk_i, .rst_i,
  .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .port1_pin_o, .port1_pin_oe_o,
  .port2_pin_o, .port2_pin_oe_o, .receive_enable_bit_i, .clock_select_bit1_i,
  .clock_select_bit0_i, .comm_mode_bit_i, .serial_tx_data_i,
  .serial_clock_out_i, .watch_timer_out_i);
